// [inc/cdrls_pkg.sv]
// Constants and types for the recovery lock controller
//
// Operation
// - After power-up or any receiver reset, each channel starts in reference-lock.
// - In reference-lock the phase detector is off and serial data is ignored.
// - In data-lock the phase detector is on and tracks data for best phase.
// - Lock state changes in automatic mode or in manual mode.
// - Automatic mode enters data-lock alone, only when all entry conditions hold.
// - Signal-present gates automatic entry only in PIPE mode; ignored otherwise.
// - Automatic entry also needs recovered clock within the ppm threshold.
// - Each channel selects its reference clock from one of two PLLs.
package cdrls_pkg;
  localparam int CDRLS_NCH = 4;
  localparam logic [31:0] CDRLS_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] CDRLS_ADDR_PPM = 32'h0000_0004;
  localparam logic [31:0] CDRLS_ADDR_STAT = 32'h0000_0008;
  localparam logic [31:0] CDRLS_ADDR_LOCKT = 32'h0000_000c;
  // Control field positions, one bit per channel in each nibble
  localparam int CDRLS_CTRL_MANUAL = 0;
  localparam int CDRLS_CTRL_PIPE = 4;
  localparam int CDRLS_CTRL_PLLSEL = 8;
  localparam int CDRLS_CTRL_FREF = 12;
  localparam int CDRLS_CTRL_FDATA = 16;
  localparam logic [31:0] CDRLS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CDRLS_CTRL_MASK = 32'h0000_0fff;
  localparam logic [15:0] CDRLS_PPM_RST = 16'h0064;
  localparam int CDRLS_FREQ_LOCK_NS = 4000;
  localparam int CDRLS_CLK_NS = 4;
  localparam int CDRLS_FREQ_LOCK_CYC = (CDRLS_FREQ_LOCK_NS + CDRLS_CLK_NS - 1) / CDRLS_CLK_NS;
  typedef enum logic [1:0] {
    CDRLS_REF = 2'b01,
    CDRLS_DATA = 2'b10
  } cdrls_state_e;
endpackage

// [rtl/cdrls_chan.sv]
// One channel's reference-lock / data-lock state machine
`timescale 1ns/1ps
module cdrls_chan
  import cdrls_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic rx_reset, // Receiver reset, synchronous
  input wire logic manual_mode, // Manual lock mode
  input wire logic pipe_mode, // PCI Express PIPE mode
  input wire logic force_ref, // Manual reference-lock request
  input wire logic force_data, // Manual data-lock request
  input wire logic sig_present, // Signal-present, synchronised
  input wire logic freq_ok, // Recovered clock within threshold
  output logic in_data_lock // High in data-lock
);
  cdrls_state_e state_reg, state_next;

  always_comb
  begin
    state_next = state_reg;
    if (rx_reset)
      state_next = CDRLS_REF;
    else if (manual_mode)
    begin
      if (force_ref)
        state_next = CDRLS_REF;
      else if (force_data)
        state_next = CDRLS_DATA;
    end
    else
    begin
      case (state_reg)
        CDRLS_REF:
          if (freq_ok && (sig_present || !pipe_mode))
            state_next = CDRLS_DATA;
        CDRLS_DATA:
          state_next = CDRLS_DATA;
        default:
          state_next = CDRLS_REF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= CDRLS_REF;
    else
      state_reg <= state_next;
  end

  assign in_data_lock = (state_reg == CDRLS_DATA);
endmodule

// [rtl/cdrls_top.sv]
// Lock controller for all receive channels with APB registers
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cdrls_top
  import cdrls_pkg::*;
(
  input wire logic pclk, // Clock, 250 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [31:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [CDRLS_NCH-1:0] rx_reset, // Per-channel receiver reset pins
  input wire logic [CDRLS_NCH-1:0] sig_detect, // Per-channel signal present pins
  input wire logic [15:0] ppm_diff_a, // Measured ppm offset vs PLL A
  input wire logic [15:0] ppm_diff_b, // Measured ppm offset vs PLL B
  output logic [CDRLS_NCH-1:0] pd_enable, // Phase detector enable
  output logic [CDRLS_NCH-1:0] ref_pll_sel, // Reference PLL select, 1 = B
  output logic [CDRLS_NCH-1:0] freq_locked // High while in data-lock
);
  logic [31:0] ctrl_reg, ctrl_next;
  logic [15:0] ppm_reg, ppm_next;
  logic [CDRLS_NCH-1:0] lockt_reg, lockt_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [CDRLS_NCH-1:0] rst_s1, rst_s2, sd_s1, sd_s2;
  logic [15:0] pa_s1, pa_s2, pb_s1, pb_s2;
  logic [CDRLS_NCH-1:0] pd_reg, sel_reg, lock_reg;
  logic [CDRLS_NCH-1:0] data_lock;
  logic [CDRLS_NCH-1:0] fref_pulse, fdata_pulse;
  logic [CDRLS_NCH-1:0] fref_reg, fdata_reg;
  logic wr_ctrl, wr_ppm, wr_lockt;
  logic acc;

  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] r);
    addr_hit = (a == r);
  endfunction

  // Pins pass two flops; multibit ppm measure assumed quasi-static
  // Resets sync to asserted so channels sit in reference-lock until the pin is seen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_s1 <= '1;
      rst_s2 <= '1;
      sd_s1 <= '0;
      sd_s2 <= '0;
      pa_s1 <= '0;
      pa_s2 <= '0;
      pb_s1 <= '0;
      pb_s2 <= '0;
    end
    else
    begin
      rst_s1 <= rx_reset;
      rst_s2 <= rst_s1;
      sd_s1 <= sig_detect;
      sd_s2 <= sd_s1;
      pa_s1 <= ppm_diff_a;
      pa_s2 <= pa_s1;
      pb_s1 <= ppm_diff_b;
      pb_s2 <= pb_s1;
    end
  end

  // Access edge of any transfer; writes and force pulses act only here
  assign acc = psel && penable && pready_reg;

  // One write strobe per writable register (ctrl, ppm, lockt), raised only at the access edge
  always_comb
  begin
    wr_ctrl = 1'b0;
    wr_ppm = 1'b0;
    wr_lockt = 1'b0;
    if (acc && pwrite)
    begin
      if (addr_hit(paddr, CDRLS_ADDR_CTRL))
        wr_ctrl = 1'b1;
      else if (addr_hit(paddr, CDRLS_ADDR_PPM))
        wr_ppm = 1'b1;
      else if (addr_hit(paddr, CDRLS_ADDR_LOCKT))
        wr_lockt = 1'b1;
    end
  end

  // Zero-wait decode: pready answers in the first access cycle
  always_comb
  begin
    ctrl_next = ctrl_reg;
    ppm_next = ppm_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = psel && !penable;
    fref_pulse = '0;
    fdata_pulse = '0;
    if (psel && !penable)
    begin
      if (addr_hit(paddr, CDRLS_ADDR_CTRL))
        prdata_next = ctrl_reg;
      else if (addr_hit(paddr, CDRLS_ADDR_PPM))
        prdata_next = {16'h0000, ppm_reg};
      else if (addr_hit(paddr, CDRLS_ADDR_STAT))
        prdata_next = {24'h000000, sel_reg, data_lock};
      else if (addr_hit(paddr, CDRLS_ADDR_LOCKT))
        prdata_next = {28'h0000000, lockt_reg};
      else
      begin
        prdata_next = 32'h0000_0000;
        pslverr_next = 1'b1;
      end
    end
    else if (acc)
    begin
      pslverr_next = 1'b0;
      if (wr_ctrl)
      begin
        // Force bits are pulses; they never read back as set
        ctrl_next = pwdata & CDRLS_CTRL_MASK;
        fref_pulse = pwdata[CDRLS_CTRL_FREF +: CDRLS_NCH];
        fdata_pulse = pwdata[CDRLS_CTRL_FDATA +: CDRLS_NCH];
      end
      else if (wr_ppm)
        ppm_next = pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= CDRLS_CTRL_RST;
      ppm_reg <= CDRLS_PPM_RST;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      ppm_reg <= ppm_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next & pready_next;
    end
  end

  // Force pulses act one edge after the write, so a write that also sets
  // manual mode already shows the new mode bit to the channel
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fref_reg <= '0;
      fdata_reg <= '0;
    end
    else
    begin
      fref_reg <= fref_pulse;
      fdata_reg <= fdata_pulse;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CDRLS_NCH; g++)
    begin : ch
      logic [15:0] diff;
      logic fok;
      assign diff = ctrl_reg[CDRLS_CTRL_PLLSEL + g] ? pb_s2 : pa_s2;
      // An offset equal to the threshold still counts as within it
      assign fok = (diff <= ppm_reg);
      cdrls_chan u_chan (
        .pclk(pclk),
        .presetn(presetn),
        .rx_reset(rst_s2[g]),
        .manual_mode(ctrl_reg[CDRLS_CTRL_MANUAL + g]),
        .pipe_mode(ctrl_reg[CDRLS_CTRL_PIPE + g]),
        .force_ref(fref_reg[g]),
        .force_data(fdata_reg[g]),
        .sig_present(sd_s2[g]),
        .freq_ok(fok),
        .in_data_lock(data_lock[g])
      );
    end
  endgenerate

  // Sticky: set on entry to data-lock wins over a same-cycle clear by write
  always_comb
  begin
    lockt_next = lockt_reg | (data_lock & ~lock_reg);
    if (wr_lockt)
      lockt_next = (lockt_reg & ~pwdata[CDRLS_NCH-1:0]) | (data_lock & ~lock_reg);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lockt_reg <= '0;
      pd_reg <= '0;
      sel_reg <= '0;
      lock_reg <= '0;
    end
    else
    begin
      lockt_reg <= lockt_next;
      pd_reg <= data_lock;
      sel_reg <= ctrl_reg[CDRLS_CTRL_PLLSEL +: CDRLS_NCH];
      lock_reg <= data_lock;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pd_enable = pd_reg;
  assign ref_pll_sel = sel_reg;
  assign freq_locked = lock_reg;
endmodule

// [tb/cdrls_properties.sv]
// Port checks for the lock controller
`timescale 1ns/1ps
module cdrls_properties
  import cdrls_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Write
  input wire logic [31:0] paddr, // Address
  input wire logic [31:0] pwdata, // Data
  input wire logic pready, // Ready
  input wire logic [CDRLS_NCH-1:0] rx_reset, // Rx reset
  input wire logic [CDRLS_NCH-1:0] pd_enable, // Detector
  input wire logic [CDRLS_NCH-1:0] ref_pll_sel, // PLL
  input wire logic [CDRLS_NCH-1:0] freq_locked // Locked
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wc;
  assign wc = psel && penable && pready && pwrite && paddr == CDRLS_ADDR_CTRL;
  property p_rst; (freq_locked & rx_reset & $past(rx_reset, 4)) == '0; endproperty
  property p_pwr; $rose(presetn) |-> freq_locked == '0; endproperty
  property p_pd; pd_enable == freq_locked; endproperty
  property p_sel; wc |-> ##2 ref_pll_sel == $past(pwdata[11:8], 2); endproperty
  property p_fref; wc && pwdata[0] && pwdata[12] |-> ##[1:5] !freq_locked[0]; endproperty
  property p_fdat;
    wc && pwdata[0] && pwdata[16] && !pwdata[12] && !rx_reset[0] && !$past(rx_reset[0])
      |-> ##[1:5] freq_locked[0];
  endproperty
  property p_ans; psel && !penable |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  a_rst: assert property (p_rst) else $error("lock in reset");
  a_pwr: assert property (p_pwr) else $error("lock at start");
  a_pd: assert property (p_pd) else $error("detector");
  a_sel: assert property (p_sel) else $error("pll select");
  a_fref: assert property (p_fref) else $error("force ref");
  a_fdat: assert property (p_fdat) else $error("force data");
  a_ans: assert property (p_ans) else $error("no ready");
  a_one: assert property (p_one) else $error("long ready");
  c_lock: cover property ($rose(freq_locked[0]));
  c_wc: cover property (wc);
  c_rst: cover property ($rose(rx_reset[0]));
endmodule
bind cdrls_top cdrls_properties u_prop (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .rx_reset, .pd_enable, .ref_pll_sel, .freq_locked);

// [tb/cdrls_user_ctl.sv]
// Model of the user reset sequencer around a PLL change
`timescale 1ns/1ps
module cdrls_user_ctl
  import cdrls_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic go, // Start
  input wire logic [CDRLS_NCH-1:0] freq_locked, // Locked
  output logic [CDRLS_NCH-1:0] rx_reset, // Rx reset
  output logic done // Rx logic free
);
  int cnt;
  // The hold covers the PLL update, then all channels are released together
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      {rx_reset, done, cnt} <= '0;
    else if (go)
      {rx_reset, done, cnt} <= {4'hf, 1'b0, 32'd0};
    else if (|rx_reset)
      {rx_reset, cnt} <= (cnt == 39) ? '0 : {rx_reset, cnt + 1};
    else if (!done)
      {done, cnt} <= {cnt >= CDRLS_FREQ_LOCK_CYC, freq_locked == '1 ? cnt + 1 : 0};
endmodule

// [tb/testbench.sv]
// Self-checking bench for the lock controller
`timescale 1ns/1ps
module testbench import cdrls_pkg::*;;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, done, err;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr;
  logic [3:0] rx_reset, sig_detect = '0, pd_enable, ref_pll_sel, freq_locked;
  logic [15:0] ppm_diff_a = 16'h0200, ppm_diff_b = 16'h0010;
  int miscompares = 0, compares = 0, cyc = 0;
  always #2 pclk = ~pclk;
  cdrls_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_reset, .sig_detect, .ppm_diff_a, .ppm_diff_b, .pd_enable, .ref_pll_sel,
    .freq_locked);
  cdrls_user_ctl partner (.pclk, .presetn, .go, .freq_locked, .rx_reset, .done);
  task end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait on a slave that never answers
    while (pready !== 1'b1)
      @(posedge pclk);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  // Lock flags move a few edges after their cause, so poll with a limit
  task wfl(input logic [3:0] e);
    repeat (30)
      if (freq_locked !== e)
        @(posedge pclk);
    chk("freq_locked", 32'(freq_locked), 32'(e));
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim;
    end
  end
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("outputs", 32'({pd_enable, ref_pll_sel, freq_locked}), '0);
    apb(0, CDRLS_ADDR_PPM, 0);
    chk("ppm", rd, 32'(CDRLS_PPM_RST));
    apb(0, CDRLS_ADDR_CTRL, 0);
    chk("ctrl", rd, CDRLS_CTRL_RST);
    wfl(4'h0);
    apb(1, CDRLS_ADDR_CTRL, 32'h0c20);
    wfl(4'hc);
    chk("pll", 32'(ref_pll_sel), 32'hc);
    apb(1, CDRLS_ADDR_PPM, 32'h0200);
    wfl(4'hd);
    sig_detect <= 4'h2;
    wfl(4'hf);
    apb(0, CDRLS_ADDR_STAT, 0);
    chk("stat", rd, 32'hcf);
    apb(0, 32'h10, 0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    apb(0, CDRLS_ADDR_LOCKT, 0);
    chk("lock entry", rd, 32'hf);
    apb(1, CDRLS_ADDR_LOCKT, 32'hf);
    apb(0, CDRLS_ADDR_LOCKT, 0);
    chk("entry clear", rd, 32'h0);
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    wfl(4'h0);
    repeat (1200)
      if (done !== 1'b1)
        @(posedge pclk);
    chk("relock", 32'({done, freq_locked}), 32'h1f);
    apb(0, CDRLS_ADDR_LOCKT, 0);
    chk("relock entry", rd, 32'hf);
    apb(1, CDRLS_ADDR_CTRL, 32'h1c21);
    wfl(4'he);
    apb(1, CDRLS_ADDR_CTRL, 32'h11c21);
    repeat (3) @(posedge pclk);
    chk("ref wins", 32'(freq_locked), 32'he);
    apb(1, CDRLS_ADDR_CTRL, 32'h10c21);
    wfl(4'hf);
    chk("detector", 32'(pd_enable), 32'hf);
    end_sim;
  end
endmodule
